// ### hdl/adcs_i2c.sv
`timescale 1ns/1ns
`default_nettype none
module adcs_i2c
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [6:0] i_slave_addr,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [15:0] i_rd_data,
    output logic o_sda_oe,
    output logic [1:0] o_ptr,
    output logic o_wr_en,
    output logic [15:0] o_wr_data
);
    import adcs_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_RX, S_TX, S_TX_ACK} adcs_i2c_e;

    typedef struct packed {
        adcs_i2c_e st;
        logic scl_d;
        logic sda_d;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [1:0] byte_idx;
        logic rw;
        logic mack;
        logic tx_lo;
        logic [1:0] ptr;
        logic [7:0] hi;
        logic [15:0] txword;
        logic sda_oe;
        logic wr_en;
        logic [15:0] wr_data;
    } adcs_i2c_s;

    adcs_i2c_s q;
    adcs_i2c_s n;

    always_comb
    begin
        n = q;
        n.scl_d = i_scl;
        n.sda_d = i_sda;
        n.wr_en = 1'b0;
        if (q.scl_d && i_scl && q.sda_d && !i_sda)
        begin
            n.st = S_ADDR;
            n.bitcnt = 4'h0;
            n.byte_idx = 2'h0;
            n.sda_oe = 1'b0;
        end
        else if (q.scl_d && i_scl && !q.sda_d && i_sda)
        begin
            n.st = S_IDLE;
            n.sda_oe = 1'b0;
        end
        else if (!q.scl_d && i_scl)
        begin
            case (q.st)
                S_ADDR, S_RX:
                begin
                    n.shreg = {q.shreg[6:0], i_sda};
                    n.bitcnt = q.bitcnt + 4'h1;
                end
                S_TX_ACK:
                begin
                    n.mack = !i_sda;
                    if (i_sda)
                    begin
                        n.st = S_IDLE;
                    end
                end
                default:
                begin
                end
            endcase
        end
        else if (q.scl_d && !i_scl)
        begin
            case (q.st)
                S_ADDR:
                begin
                    if (q.bitcnt == ADCS_BITS_PER_BYTE)
                    begin
                        if (q.shreg[7:1] == i_slave_addr)
                        begin
                            n.st = S_ACK;
                            n.rw = q.shreg[0];
                            n.sda_oe = 1'b1;
                            n.txword = i_rd_data;
                        end
                        else
                        begin
                            n.st = S_IDLE;
                        end
                    end
                end
                S_RX:
                begin
                    if (q.bitcnt == ADCS_BITS_PER_BYTE)
                    begin
                        n.st = S_ACK;
                        n.sda_oe = 1'b1;
                        case (q.byte_idx)
                            2'h0: n.ptr = q.shreg[1:0]; // see (R11)
                            2'h1: n.hi = q.shreg;
                            2'h2:
                            begin
                                n.wr_en = 1'b1;
                                n.wr_data = {q.hi, q.shreg};
                            end
                            default:
                            begin
                            end
                        endcase
                        if (q.byte_idx != 2'h3)
                        begin
                            n.byte_idx = q.byte_idx + 2'h1;
                        end
                    end
                end
                S_ACK:
                begin
                    n.bitcnt = 4'h0;
                    if (q.rw)
                    begin
                        // The high byte goes out first, then the low byte.
                        n.st = S_TX; // see (R13)
                        n.shreg = q.txword[15:8];
                        n.tx_lo = 1'b1;
                        n.sda_oe = !q.txword[15];
                    end
                    else
                    begin
                        n.st = S_RX;
                        n.sda_oe = 1'b0;
                    end
                end
                S_TX:
                begin
                    if (q.bitcnt[2:0] == ADCS_LAST_TX_BIT)
                    begin
                        n.st = S_TX_ACK;
                        n.sda_oe = 1'b0;
                    end
                    else
                    begin
                        n.shreg = {q.shreg[6:0], 1'b0};
                        n.bitcnt = q.bitcnt + 4'h1;
                        n.sda_oe = !q.shreg[6];
                    end
                end
                S_TX_ACK:
                begin
                    if (q.mack)
                    begin
                        n.st = S_TX; // see (R13)
                        n.bitcnt = 4'h0;
                        n.shreg = q.tx_lo ? q.txword[7:0] : q.txword[15:8];
                        n.tx_lo = !q.tx_lo;
                        n.sda_oe = q.tx_lo ? !q.txword[7] : !q.txword[15];
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            q <= '{st: S_IDLE, scl_d: 1'b1, sda_d: 1'b1, default: '0};
        end
        else
        begin
            q <= n;
        end
    end

    assign o_sda_oe = q.sda_oe;
    assign o_ptr = q.ptr;
    assign o_wr_en = q.wr_en;
    assign o_wr_data = q.wr_data;

endmodule
`default_nettype wire

// ### hdl/adcs_top.sv
// Operation
// (R01) Writing 1 to the start bit while powered down starts exactly one conversion.
// (R02) Writing 0 to the start bit, or writing it during a conversion, does nothing.
// (R03) The start bit reads 0 while converting and 1 otherwise, sits at bit 15, resets to 1.
// (R04) Input select codes 000..011 pick the pairs 0/1, 0/3, 1/3 and 2/3, default 000.
// (R05) Input select codes 100..111 measure input 0..3 against ground.
// (R06) Gain codes 000..100 give 6.144, 4.096, 2.048 (default), 1.024 and 0.512 V ranges.
// (R07) Gain codes 101 and 110 both give the 0.256 V range.
// (R08) The mode bit at 8 picks continuous when 0 and single-shot when 1, resets to 1.
// (R09) Rate codes 000..101 give 128, 250, 490, 920, 1600 (default) and 2400 SPS.
// (R10) Rate codes 110 and 111 both give 3300 SPS.
// (R11) The host selects the setup register with pointer value 01 before access.
// (R12) The setup register is 16 bits wide and resets to 8583h.
// (R13) A read sends the high byte first, then the low byte.
// (R14) New select, gain and rate settings apply from the next conversion on.
`timescale 1ns/1ns
`default_nettype none
module adcs_top
#(
    parameter int unsigned P_CORE_CLK_HZ = adcs_pkg::ADCS_CORE_CLK_HZ,
    parameter logic [6:0] P_SLAVE_ADDR = adcs_pkg::ADCS_SLAVE_ADDR
)
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    output logic o_conv_busy,
    output logic o_conv_start,
    output logic o_conv_done,
    output logic o_continuous,
    output logic [1:0] o_positive_input,
    output logic [1:0] o_negative_input,
    output logic o_negative_is_ground,
    output logic [2:0] o_full_scale_range,
    output logic [2:0] o_sample_rate_select
);
    import adcs_pkg::*;

    typedef enum logic {C_IDLE, C_BUSY} adcs_conv_e;

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic sda_m;
        logic sda_s;
        logic [2:0] input_select;
        logic [2:0] gain_range_select;
        logic mode;
        logic [2:0] sample_rate_select;
        logic [4:0] comp;
        adcs_conv_e st;
        logic [23:0] cnt;
        logic conv_start;
        logic conv_done;
        logic [1:0] pos;
        logic [1:0] neg;
        logic neg_gnd;
        logic [2:0] full_scale_range;
        logic [2:0] rate;
        logic busy;
        logic cont;
    } adcs_top_s;

    adcs_top_s q;
    adcs_top_s n;

    logic [1:0] ptr;
    logic wr_en;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    logic sda_oe;
    logic wr_setup;
    logic do_start;

    // Every rate is far below the counter's tick, so the period is rounded down to whole cycles.
    function automatic logic [23:0] conv_cycles(input logic [2:0] rate);
        int unsigned sps;
        case (rate) // see (R09)
            3'h0: sps = ADCS_SPS_128;
            3'h1: sps = ADCS_SPS_250;
            3'h2: sps = ADCS_SPS_490;
            3'h3: sps = ADCS_SPS_920;
            3'h4: sps = ADCS_SPS_1600;
            3'h5: sps = ADCS_SPS_2400;
            default: sps = ADCS_SPS_3300; // see (R10)
        endcase
        conv_cycles = 24'(P_CORE_CLK_HZ / sps);
    endfunction

    adcs_i2c u_i2c
    (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_slave_addr(P_SLAVE_ADDR),
        .i_scl(q.scl_s),
        .i_sda(q.sda_s),
        .i_rd_data(rd_data),
        .o_sda_oe(sda_oe),
        .o_ptr(ptr),
        .o_wr_en(wr_en),
        .o_wr_data(wr_data)
    );

    assign wr_setup = wr_en && (ptr == ADCS_PTR_SETUP); // see (R11)

    always_comb
    begin
        rd_data = ADCS_READ_NONE;
        if (ptr == ADCS_PTR_SETUP) // see (R11)
        begin
            rd_data = {q.st == C_IDLE, q.input_select, q.gain_range_select,
                q.mode, q.sample_rate_select, q.comp}; // see (R03)
        end
    end

    always_comb
    begin
        n = q;
        do_start = 1'b0;
        n.scl_m = i_scl;
        n.scl_s = q.scl_m;
        n.sda_m = i_sda;
        n.sda_s = q.sda_m;
        n.conv_start = 1'b0;
        n.conv_done = 1'b0;
        if (wr_setup)
        begin
            n.input_select = wr_data[ADCS_MUX_LSB +: 3];
            n.gain_range_select = wr_data[ADCS_PGA_LSB +: 3];
            n.mode = wr_data[ADCS_MODE_BIT]; // see (R08)
            n.sample_rate_select = wr_data[ADCS_RATE_LSB +: 3];
            n.comp = wr_data[ADCS_COMP_LSB +: 5];
        end
        case (q.st)
            C_IDLE:
            begin
                // A 0 in the start bit is simply not a start request.
                if ((wr_setup && wr_data[ADCS_OS_BIT]) || !n.mode) // see (R01) (R02)
                begin
                    do_start = 1'b1;
                end
            end
            C_BUSY:
            begin
                // The start bit is not looked at here, so writes to it are dropped.
                if (q.cnt == 24'h0) // see (R02)
                begin
                    n.conv_done = 1'b1;
                    n.st = C_IDLE;
                    if (!n.mode) // see (R08)
                    begin
                        do_start = 1'b1;
                    end
                end
                else
                begin
                    n.cnt = q.cnt - 24'h1;
                end
            end
            default:
            begin
                n.st = C_IDLE;
            end
        endcase
        if (do_start)
        begin
            // Settings are latched only here, so a running conversion keeps its own.
            n.st = C_BUSY; // see (R14)
            n.conv_start = 1'b1;
            n.cnt = conv_cycles(n.sample_rate_select) - 24'h1;
            n.rate = (n.sample_rate_select[2:1] == 2'h3) ? ADCS_RATE_3300
                : n.sample_rate_select; // see (R10)
            n.full_scale_range = (n.gain_range_select > ADCS_FSR_0256) ? ADCS_FSR_0256
                : n.gain_range_select; // see (R06) (R07)
            if (n.input_select[2])
            begin
                n.pos = n.input_select[1:0]; // see (R05)
                n.neg = 2'h0;
                n.neg_gnd = 1'b1;
            end
            else
            begin
                n.neg_gnd = 1'b0;
                case (n.input_select[1:0]) // see (R04)
                    2'h0:
                    begin
                        n.pos = 2'h0;
                        n.neg = 2'h1;
                    end
                    2'h1:
                    begin
                        n.pos = 2'h0;
                        n.neg = 2'h3;
                    end
                    2'h2:
                    begin
                        n.pos = 2'h1;
                        n.neg = 2'h3;
                    end
                    default:
                    begin
                        n.pos = 2'h2;
                        n.neg = 2'h3;
                    end
                endcase
            end
        end
        // Status outputs are registered copies, so the pins never see decode glitches.
        n.busy = (n.st == C_BUSY);
        n.cont = !n.mode; // see (R08)
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            q <= '{scl_m: 1'b1, scl_s: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
                input_select: ADCS_SETUP_RESET[ADCS_MUX_LSB +: 3],
                gain_range_select: ADCS_SETUP_RESET[ADCS_PGA_LSB +: 3],
                mode: ADCS_SETUP_RESET[ADCS_MODE_BIT],
                sample_rate_select: ADCS_SETUP_RESET[ADCS_RATE_LSB +: 3],
                comp: ADCS_SETUP_RESET[ADCS_COMP_LSB +: 5],
                st: C_IDLE, default: '0}; // see (R12)
        end
        else
        begin
            q <= n;
        end
    end

    // The pin is only ever pulled low; the bus pull-up makes the high level.
    assign o_sda_o = 1'b0;
    assign o_sda_oe = sda_oe;
    assign o_conv_busy = q.busy;
    assign o_conv_start = q.conv_start;
    assign o_conv_done = q.conv_done;
    assign o_continuous = q.cont;
    assign o_positive_input = q.pos;
    assign o_negative_input = q.neg;
    assign o_negative_is_ground = q.neg_gnd;
    assign o_full_scale_range = q.full_scale_range;
    assign o_sample_rate_select = q.rate;

endmodule
`default_nettype wire

// ### inc/adcs_pkg.sv
package adcs_pkg;

    localparam logic [1:0] ADCS_PTR_RESULT = 2'h0;
    localparam logic [1:0] ADCS_PTR_SETUP = 2'h1;

    localparam int ADCS_OS_BIT = 15;
    localparam int ADCS_MUX_LSB = 12;
    localparam int ADCS_PGA_LSB = 9;
    localparam int ADCS_MODE_BIT = 8;
    localparam int ADCS_RATE_LSB = 5;
    localparam int ADCS_COMP_LSB = 0;

    localparam logic [15:0] ADCS_SETUP_RESET = 16'h8583;
    localparam logic [15:0] ADCS_READ_NONE = 16'h0000;

    localparam logic [2:0] ADCS_FSR_0256 = 3'h5;
    localparam logic [2:0] ADCS_RATE_3300 = 3'h6;

    localparam int unsigned ADCS_CORE_CLK_HZ = 100_000_000;
    localparam int unsigned ADCS_SPS_128 = 128;
    localparam int unsigned ADCS_SPS_250 = 250;
    localparam int unsigned ADCS_SPS_490 = 490;
    localparam int unsigned ADCS_SPS_920 = 920;
    localparam int unsigned ADCS_SPS_1600 = 1600;
    localparam int unsigned ADCS_SPS_2400 = 2400;
    localparam int unsigned ADCS_SPS_3300 = 3300;

    // Arbitrary default bus address; the integrator sets the real one.
    localparam logic [6:0] ADCS_SLAVE_ADDR = 7'h2a;

    localparam logic [3:0] ADCS_BITS_PER_BYTE = 4'h8;
    localparam logic [2:0] ADCS_LAST_TX_BIT = 3'h7;

endpackage

// ### verification/adc_conversion_setup_tb.sv
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_setup_tb;
    import adcs_pkg::*;
    // Scaled clock rate keeps the slowest conversion at 2000 cycles.
    localparam int unsigned CLK_HZ = 256000;
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic scl, m_oe, sda, sda_o, sda_oe, busy, start, done, cont, gnd;
    logic [1:0] pos, neg;
    logic [2:0] full_scale_range, rate;
    logic [15:0] rd;
    int miscompares = 0;
    int n_checks = 0;
    int starts = 0;
    int dones = 0;
    always #5 i_core_clk = !i_core_clk;
    assign sda = (sda_oe ? sda_o : 1'b1) & !m_oe;
    always @(posedge i_core_clk)
    begin
        if (start === 1'b1)
            starts <= starts + 1;
        if (done === 1'b1)
            dones <= dones + 1;
    end
    adcs_top #(.P_CORE_CLK_HZ(CLK_HZ)) u_dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_conv_busy(busy),
        .o_conv_start(start), .o_conv_done(done), .o_continuous(cont),
        .o_positive_input(pos), .o_negative_input(neg), .o_negative_is_ground(gnd),
        .o_full_scale_range(full_scale_range), .o_sample_rate_select(rate));
    adcs_bus_master #(.P_ADDR(ADCS_SLAVE_ADDR)) u_bus (.i_core_clk(i_core_clk),
        .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 3000)
        begin
            @(posedge i_core_clk);
            n++;
        end
        check("idle", 16'h0, {15'h0, busy});
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_reset();
        logic [15:0] o;
        o = {sda_oe, busy, start, done, cont, gnd, pos, neg, full_scale_range, rate};
        check("outputs", 16'h0, o);
        u_bus.rd_setup(rd);
        check("setup", ADCS_SETUP_RESET, rd);
        // A word for another pointer would start continuous mode if it leaked into setup.
        u_bus.wr_reg(ADCS_PTR_RESULT, 16'h0000);
        check("other ptr busy", 16'h0, {15'h0, busy});
        u_bus.rd_reg(ADCS_PTR_RESULT, rd);
        check("other ptr read", ADCS_READ_NONE, rd);
        u_bus.rd_setup(rd);
        check("setup kept", ADCS_SETUP_RESET, rd);
        $display("test reset done");
    endtask
    task automatic t_codes();
        logic [2:0] k;
        logic [15:0] e;
        int s;
        int d;
        for (int i = 0; i < 8; i++)
        begin
            k = i[2:0];
            s = starts;
            d = dones;
            u_bus.wr_setup({1'b1, k, k, 1'b1, k, 5'h03});
            e = {11'h0, k[2] ? k[1:0] : ((k == 3'h0) ? 2'h0 : k[1:0] - 2'h1),
                k[2] ? 2'h0 : ((k == 3'h0) ? 2'h1 : 2'h3), k[2]};
            check("inputs", e, {11'h0, pos, neg, gnd});
            check("range", {13'h0, (k > 3'h5) ? 3'h5 : k}, {13'h0, full_scale_range});
            check("rate", {13'h0, (k == 3'h7) ? 3'h6 : k}, {13'h0, rate});
            wait_idle();
            // One more edge lets the pulse counters take the final done.
            @(posedge i_core_clk);
            check("one start", 16'h1, 16'(starts - s));
            check("one done", 16'h1, 16'(dones - d));
        end
        $display("test codes done");
    endtask
    task automatic t_busy();
        int s;
        s = starts;
        u_bus.wr_setup(16'h8503);
        u_bus.rd_setup(rd);
        check("busy status", 16'h0503, rd);
        u_bus.wr_setup(16'hf503);
        check("held input", 16'h0, {13'h0, pos, gnd});
        wait_idle();
        check("ignored start", 16'h1, 16'(starts - s));
        u_bus.rd_setup(rd);
        check("idle status", 16'hf503, rd);
        u_bus.wr_setup(16'h7503);
        check("zero start", 16'h0, {15'h0, busy});
        $display("test busy done");
    endtask
    task automatic t_cont();
        int s;
        s = starts;
        u_bus.wr_setup(16'h04c3);
        check("continuous", 16'h1, {15'h0, cont});
        repeat (400) @(posedge i_core_clk);
        check("restarts", 16'h1, {15'h0, (starts - s) > 4});
        u_bus.rd_setup(rd);
        check("cont status", 16'h04c3, rd);
        u_bus.wr_setup(16'h05c3);
        wait_idle();
        repeat (100) @(posedge i_core_clk);
        check("stopped", 16'h0, {14'h0, busy, cont});
        $display("test continuous done");
    endtask
    initial
    begin
        repeat (4) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        t_reset();
        t_codes();
        t_busy();
        t_cont();
        check("bus acks", 16'h0, 16'(u_bus.nacks));
        conclude();
    end
    initial
    begin
        repeat (40000) @(posedge i_core_clk);
        miscompares++;
        $display("Error watchdog expected end seen hang");
        conclude();
    end
endmodule
bind adcs_top adcs_top_properties #(.P_CORE_CLK_HZ(P_CORE_CLK_HZ)) u_props (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .o_conv_busy(o_conv_busy),
    .o_conv_start(o_conv_start), .o_conv_done(o_conv_done),
    .o_positive_input(o_positive_input), .o_negative_input(o_negative_input),
    .o_negative_is_ground(o_negative_is_ground), .o_full_scale_range(o_full_scale_range),
    .o_sample_rate_select(o_sample_rate_select));
`default_nettype wire

// ### verification/adcs_bus_master.sv
`timescale 1ns/1ns
`default_nettype none
module adcs_bus_master
#(
    parameter logic [6:0] P_ADDR = 7'h2a
)
(
    input wire logic i_core_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe
);
    import adcs_pkg::*;
    int nacks = 0;
    initial
    begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    // Data moves only while the bus clock is low; it idles high between frames.
    task automatic bit_io(input logic b, output logic r);
        o_scl <= 1'b0;
        @(posedge i_core_clk);
        o_sda_oe <= !b;
        repeat (3) @(posedge i_core_clk);
        o_scl <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        r = i_sda;
        repeat (2) @(posedge i_core_clk);
    endtask
    task automatic xfer(input logic [7:0] d, input logic ma, input logic chk,
        output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(ma, r);
        if (chk && r)
            nacks++;
    endtask
    task automatic go(input logic [7:0] a);
        logic [7:0] q;
        o_sda_oe <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        xfer(a, 1'b1, 1'b1, q);
    endtask
    task automatic halt();
        o_scl <= 1'b0;
        @(posedge i_core_clk);
        o_sda_oe <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        o_scl <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        o_sda_oe <= 1'b0;
        repeat (8) @(posedge i_core_clk);
    endtask
    task automatic wr_reg(input logic [1:0] p, input logic [15:0] w);
        logic [7:0] q;
        go({P_ADDR, 1'b0});
        xfer({6'h00, p}, 1'b1, 1'b1, q);
        xfer(w[15:8], 1'b1, 1'b1, q);
        xfer(w[7:0], 1'b1, 1'b1, q);
        halt();
    endtask
    task automatic rd_reg(input logic [1:0] p, output logic [15:0] w);
        logic [7:0] q;
        go({P_ADDR, 1'b0});
        xfer({6'h00, p}, 1'b1, 1'b1, q);
        halt();
        go({P_ADDR, 1'b1});
        xfer(8'hff, 1'b0, 1'b0, q);
        w[15:8] = q;
        xfer(8'hff, 1'b1, 1'b0, q);
        w[7:0] = q;
        halt();
    endtask
    task automatic wr_setup(input logic [15:0] w);
        wr_reg(ADCS_PTR_SETUP, w);
    endtask
    task automatic rd_setup(output logic [15:0] w);
        rd_reg(ADCS_PTR_SETUP, w);
    endtask
endmodule
`default_nettype wire

// ### verification/adcs_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module adcs_top_properties
#(
    parameter int unsigned P_CORE_CLK_HZ = adcs_pkg::ADCS_CORE_CLK_HZ
)
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic o_conv_busy,
    input wire logic o_conv_start,
    input wire logic o_conv_done,
    input wire logic [1:0] o_positive_input,
    input wire logic [1:0] o_negative_input,
    input wire logic o_negative_is_ground,
    input wire logic [2:0] o_full_scale_range,
    input wire logic [2:0] o_sample_rate_select
);
    import adcs_pkg::*;
    int unsigned run;
    int unsigned want;
    int unsigned len;
    logic [10:0] sel;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);
    assign sel = {o_positive_input, o_negative_input, o_negative_is_ground,
        o_full_scale_range, o_sample_rate_select};
    always_comb
    begin
        case (o_sample_rate_select)
            3'h0: want = P_CORE_CLK_HZ / ADCS_SPS_128;
            3'h1: want = P_CORE_CLK_HZ / ADCS_SPS_250;
            3'h2: want = P_CORE_CLK_HZ / ADCS_SPS_490;
            3'h3: want = P_CORE_CLK_HZ / ADCS_SPS_920;
            3'h4: want = P_CORE_CLK_HZ / ADCS_SPS_1600;
            3'h5: want = P_CORE_CLK_HZ / ADCS_SPS_2400;
            default: want = P_CORE_CLK_HZ / ADCS_SPS_3300;
        endcase
    end
    // Counts cycles since the last start; one cycle of slack covers where done lands.
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            run <= 0;
            len <= 0;
        end
        else if (o_conv_start)
        begin
            // The length is taken at start, as a continuous restart may bring a new rate.
            run <= 1;
            len <= want;
        end
        else if (o_conv_busy)
            run <= run + 1;
    end
    chk_start_busy: assert property (o_conv_start |-> o_conv_busy)
        else $error("start pulse without busy");
    chk_start_pulse: assert property (o_conv_start |=> !o_conv_start)
        else $error("start pulse too long");
    chk_busy_cause: assert property ($rose(o_conv_busy) |-> o_conv_start)
        else $error("busy rose without start");
    chk_single_stop: assert property (o_conv_done && !o_conv_start |=> !o_conv_busy)
        else $error("busy after last conversion");
    chk_conv_length: assert property (
        o_conv_done |-> run + 1 >= len && run <= len + 1)
        else $error("conversion length wrong");
    chk_gain_fold: assert property (o_full_scale_range <= ADCS_FSR_0256)
        else $error("gain code not folded");
    chk_rate_fold: assert property (
        o_conv_start |=> o_sample_rate_select <= ADCS_RATE_3300)
        else $error("rate code not folded");
    chk_ground_neg: assert property (
        o_negative_is_ground |-> o_negative_input == 2'h0)
        else $error("ground input not zero");
    chk_hold_setup: assert property (
        o_conv_busy && !o_conv_start && !$past(o_conv_start) |-> $stable(sel))
        else $error("settings moved mid conversion");
    cov_single: cover property (o_conv_start ##1 !o_conv_start);
    cov_restart: cover property (o_conv_done && o_conv_start);
    cov_ground: cover property (o_conv_busy && o_negative_is_ground);
endmodule
`default_nettype wire
